// ---- rss_chipset.sv ----
// Chipset model driving companion power-good and the voltage code
`timescale 1ns/1ns
`default_nettype none
module rss_chipset (
    input wire logic sys_clk,
    input wire logic ready,
    input wire logic [5:0] code_req,
    output logic companion_power_good_in,
    output logic [5:0] voltage_code
);
    always_ff @(posedge sys_clk) begin
        companion_power_good_in <= ready;
        voltage_code <= code_req;
    end
endmodule : rss_chipset
`default_nettype wire

// ---- rss_pkg.sv ----
// Package for the regulator start-up sequencer
package rss_pkg;
    // Soft-start thresholds in millivolts
    localparam logic [12:0] RSS_SHUTDOWN_MV = 13'h03e8;   // 1000 mV
    localparam logic [12:0] RSS_START_MV = 13'h05dc;      // 1500 mV
    localparam logic [12:0] RSS_RAMP_TOP_MV = 13'h0bb8;   // 3000 mV
    // Current limit sense levels in millivolts
    localparam logic [7:0] RSS_ILIM_LOW_MV = 8'h19;       // 25 mV
    localparam logic [7:0] RSS_ILIM_FULL_MV = 8'h48;      // 72 mV
    // Boot delay in switching periods
    localparam int RSS_BOOT_PERIODS = 15;
    // Voltage code decode: millivolts per step and floor
    localparam logic [10:0] RSS_CODE_STEP_MV = 11'h010;   // 16 mV
    localparam logic [10:0] RSS_CODE_MIN_MV = 11'h2bc;    // 700 mV
    localparam logic [5:0] RSS_CODE_MAX = 6'h3f;
    // Power-good window, percent
    localparam int RSS_PG_WINDOW_PCT = 10;

    typedef enum logic [1:0] {
        RSS_SHUTDOWN,
        RSS_IDLE,
        RSS_RAMP,
        RSS_RUN
    } rss_state_t;
endpackage : rss_pkg

// ---- rss_sequencer.sv ----
// Start-up sequencer logic for a two-phase step-down controller
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Hold converter idle below 1.5V soft-start; allow switching at 1.5V.
// - Ramp current limit from low to full as soft-start goes 1.5V to 3.0V.
// - Soft-start below 1V enters shutdown; external logic may drive it low.
// - After soft-start, regulate to resistor-set boot voltage, not voltage code.
// - Internal power-good rises only inside plus/minus ten percent of boot voltage.
// - Composite power-good is internal power-good AND companion power-good input.
// - Boot-done asserts only after composite power-good high for boot delay.
// - Boot delay is fifteen switching periods from composite power-good rise.
// - On boot-done, target switches from boot voltage to voltage code value.
module rss_sequencer
    import rss_pkg::*;
#(
    parameter int CNT_W = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [12:0] soft_start_mv,
    input wire logic [10:0] boot_target_mv,
    input wire logic [10:0] vout_mv,
    input wire logic switch_tick,
    input wire logic companion_power_good_in,
    input wire logic [5:0] voltage_code,
    output logic switching_enable,
    output logic shutdown,
    output logic [7:0] current_limit_mv,
    output logic [10:0] target_mv,
    output logic internal_power_good,
    output logic composite_power_good,
    output logic boot_done_select
);
    // ***********************************
    // Input synchronisers
    // ***********************************
    // Level buses are assumed to move slowly next to the clock;
    // a skewed sample caught mid-change lasts one cycle only
    logic [12:0] ss_s1_q, ss_q;
    logic [10:0] vo_s1_q, vo_q;
    logic [10:0] bt_s1_q, bt_q;
    logic [5:0] code_s1_q, code_q;
    logic cpg_s1_q, cpg_q, tick_s1_q, tick_q, tick_prev_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ss_s1_q <= '0;
            ss_q <= '0;
            vo_s1_q <= '0;
            vo_q <= '0;
            bt_s1_q <= '0;
            bt_q <= '0;
            code_s1_q <= '0;
            code_q <= '0;
            cpg_s1_q <= 1'b0;
            cpg_q <= 1'b0;
            tick_s1_q <= 1'b0;
            tick_q <= 1'b0;
            tick_prev_q <= 1'b0;
        end else begin
            ss_s1_q <= soft_start_mv;
            ss_q <= ss_s1_q;
            vo_s1_q <= vout_mv;
            vo_q <= vo_s1_q;
            bt_s1_q <= boot_target_mv;
            bt_q <= bt_s1_q;
            code_s1_q <= voltage_code;
            code_q <= code_s1_q;
            cpg_s1_q <= companion_power_good_in;
            cpg_q <= cpg_s1_q;
            tick_s1_q <= switch_tick;
            tick_q <= tick_s1_q;
            tick_prev_q <= tick_q;
        end
    end

    // Rising edge of the synced switching clock
    logic tick_rise;
    assign tick_rise = tick_q & ~tick_prev_q;

    // ***********************************
    // Soft-start state
    // ***********************************
    // Thresholds compared on the synced pin level
    rss_state_t state_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= RSS_SHUTDOWN;
        end else if (ss_q < RSS_SHUTDOWN_MV) begin
            state_q <= RSS_SHUTDOWN;
        end else if (ss_q < RSS_START_MV) begin
            state_q <= RSS_IDLE;
        end else if (ss_q < RSS_RAMP_TOP_MV) begin
            state_q <= RSS_RAMP;
        end else begin
            state_q <= RSS_RUN;
        end
    end

    // Registered so the pin controls never glitch on a state change
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            switching_enable <= 1'b0;
            shutdown <= 1'b1;
        end else begin
            switching_enable <= (state_q == RSS_RAMP) || (state_q == RSS_RUN);
            shutdown <= (state_q == RSS_SHUTDOWN);
        end
    end

    // ***********************************
    // Current limit ramp
    // ***********************************
    logic [12:0] ss_over;
    logic [19:0] ramp_prod;
    logic [7:0] ramp_add;
    // Linear ramp over the start-to-top span, floor division
    localparam logic [12:0] SPAN = RSS_RAMP_TOP_MV - RSS_START_MV;
    localparam logic [6:0] DELTA = 7'(RSS_ILIM_FULL_MV - RSS_ILIM_LOW_MV);

    always_comb begin
        ss_over = ss_q - RSS_START_MV;
        ramp_prod = 20'(ss_over) * 20'(DELTA);
        ramp_add = 8'(ramp_prod / 20'(SPAN));
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            current_limit_mv <= RSS_ILIM_LOW_MV;
        end else begin
            unique case (state_q)
                RSS_SHUTDOWN, RSS_IDLE: current_limit_mv <= RSS_ILIM_LOW_MV;
                RSS_RAMP: current_limit_mv <= RSS_ILIM_LOW_MV + ramp_add;
                RSS_RUN: current_limit_mv <= RSS_ILIM_FULL_MV;
            endcase
        end
    end

    // ***********************************
    // Power good and boot delay
    // ***********************************
    // Window is nine to eleven tenths of boot, ends included
    logic [14:0] vo_x10, bt_lo_x10, bt_hi_x10;
    logic in_window;

    always_comb begin
        vo_x10 = 15'(vo_q) * 15'(10);
        bt_lo_x10 = 15'(bt_q) * 15'(10 - RSS_PG_WINDOW_PCT / 10);
        bt_hi_x10 = 15'(bt_q) * 15'(10 + RSS_PG_WINDOW_PCT / 10);
        in_window = (vo_x10 >= bt_lo_x10) && (vo_x10 <= bt_hi_x10);
    end

    // Saturates at the boot count; any drop of composite good restarts it
    logic [CNT_W-1:0] delay_cnt_q;
    localparam logic [CNT_W-1:0] BOOT_CNT = CNT_W'(RSS_BOOT_PERIODS);

    // Held once boot done while in the run state, so later code moves cannot drop it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            internal_power_good <= 1'b0;
        end else if (state_q != RSS_RUN) begin
            internal_power_good <= 1'b0;
        end else if (!boot_done_select) begin
            internal_power_good <= in_window;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            composite_power_good <= 1'b0;
        end else begin
            composite_power_good <= internal_power_good & cpg_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            delay_cnt_q <= '0;
        end else if (!composite_power_good) begin
            delay_cnt_q <= '0;
        end else if (tick_rise && delay_cnt_q != BOOT_CNT) begin
            delay_cnt_q <= delay_cnt_q + 1'b1;
        end
    end

    // Sticky until soft-start falls back below the start level
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            boot_done_select <= 1'b0;
        end else if (state_q == RSS_SHUTDOWN || state_q == RSS_IDLE) begin
            boot_done_select <= 1'b0;
        end else if (composite_power_good && delay_cnt_q == BOOT_CNT) begin
            boot_done_select <= 1'b1;
        end
    end

    // ***********************************
    // Regulation target
    // ***********************************
    // Code counts down from the top target in fixed steps
    logic [10:0] code_mv;

    always_comb begin
        code_mv = RSS_CODE_MIN_MV
            + 11'(RSS_CODE_MAX - code_q) * RSS_CODE_STEP_MV;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            target_mv <= '0;
        end else if (boot_done_select) begin
            target_mv <= code_mv;
        end else begin
            target_mv <= bt_q;
        end
    end
endmodule : rss_sequencer
`default_nettype wire

// ---- rss_sequencer_assertions.sv ----
// Checker for the regulator start-up sequencer
`timescale 1ns/1ns
`default_nettype none
module rss_sequencer_checker
    import rss_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [12:0] soft_start_mv,
    input wire logic [10:0] boot_target_mv,
    input wire logic [10:0] vout_mv,
    input wire logic switch_tick,
    input wire logic companion_power_good_in,
    input wire logic [5:0] voltage_code,
    input wire logic switching_enable,
    input wire logic shutdown,
    input wire logic [7:0] current_limit_mv,
    input wire logic [10:0] target_mv,
    input wire logic internal_power_good,
    input wire logic composite_power_good,
    input wire logic boot_done_select
);
    // Ticks counted while composite good holds, delayed like the input sync
    logic [2:0] tk_q;
    logic [4:0] n_q;
    always_ff @(posedge sys_clk) tk_q <= {tk_q[1:0], switch_tick};
    always_ff @(posedge sys_clk)
        n_q <= (rst || !composite_power_good) ? 5'h00 : n_q + 5'(tk_q[1] & ~tk_q[2]);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_SHUTDOWN: assert property ((soft_start_mv < RSS_SHUTDOWN_MV)[*5]
        |-> shutdown && !switching_enable) else $error("shutdown missing");
    AST_IDLE: assert property ((soft_start_mv >= RSS_SHUTDOWN_MV &&
        soft_start_mv < RSS_START_MV)[*5] |-> !shutdown && !switching_enable) else $error("idle");
    AST_START: assert property ((soft_start_mv >= RSS_START_MV)[*5]
        |-> switching_enable && !shutdown) else $error("no start");
    AST_FULL: assert property ((soft_start_mv >= RSS_RAMP_TOP_MV)[*5]
        |-> current_limit_mv == RSS_ILIM_FULL_MV) else $error("limit not full");
    AST_AND: assert property (composite_power_good ==
        ($past(internal_power_good) && $past(companion_power_good_in, 3))) else $error("and");
    AST_WIN: assert property ($rose(internal_power_good) |->
        10 * $past(vout_mv, 3) >= 9 * $past(boot_target_mv, 3) &&
        10 * $past(vout_mv, 3) <= 11 * $past(boot_target_mv, 3)) else $error("window");
    AST_DELAY: assert property ($rose(boot_done_select)
        |-> $past(composite_power_good) && n_q >= 5'h0f) else $error("early boot done");
    AST_BOOT: assert property ((!boot_done_select && $stable(boot_target_mv))[*5]
        |-> target_mv == boot_target_mv) else $error("boot target");
    AST_CODE: assert property ((boot_done_select && $stable(voltage_code))[*6]
        |-> target_mv == RSS_CODE_MIN_MV + 11'((RSS_CODE_MAX - voltage_code) * RSS_CODE_STEP_MV))
        else $error("code target");
    cover property ($rose(boot_done_select));
    cover property ($fell(composite_power_good));
    cover property ($rose(shutdown));
    cover property ($rose(switching_enable));
endmodule : rss_sequencer_checker
bind rss_sequencer rss_sequencer_checker rss_sequencer_checker_inst (.*);
`default_nettype wire

// ---- test_regulator_startup_sequencer.sv ----
// Testbench for the regulator start-up sequencer
`timescale 1ns/1ns
`default_nettype none
module test_regulator_startup_sequencer;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    logic ready = 1'b0;
    logic [2:0] tc = 3'h0;
    logic [12:0] ss = 13'h0000;
    logic [10:0] boot = 11'h3e8;
    logic [10:0] vout = 11'h000;
    logic [5:0] code_req = 6'h3f;
    logic comp, sw_en, sd, ipg, cpg, done;
    logic [5:0] code;
    logic [7:0] ilim;
    logic [10:0] target;
    int n_fail = 0;
    int n_checks = 0;
    bit hung = 1'b0;
    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        tc <= tc + 3'h1;
        tick <= tc[2];
    end
    rss_chipset rss_chipset_inst (.sys_clk(sys_clk), .ready(ready), .code_req(code_req),
        .companion_power_good_in(comp), .voltage_code(code));
    rss_sequencer rss_sequencer_inst (.sys_clk(sys_clk), .rst(rst), .soft_start_mv(ss),
        .boot_target_mv(boot), .vout_mv(vout), .switch_tick(tick),
        .companion_power_good_in(comp), .voltage_code(code), .switching_enable(sw_en),
        .shutdown(sd), .current_limit_mv(ilim), .target_mv(target),
        .internal_power_good(ipg), .composite_power_good(cpg), .boot_done_select(done));
    task chk(input logic [12:0] got, input logic [12:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task summarize;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    task automatic t_levels;
        logic [12:0] lv[5] = '{13'h01f4, 13'h04b0, 13'h05dc, 13'h08ca, 13'h0bb8};
        logic [7:0] lim[5] = '{8'h19, 8'h19, 8'h19, 8'h30, 8'h48};
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            ss <= lv[i];
            repeat (8) @(negedge sys_clk);
            chk(13'(sd), 13'(i == 0));
            chk(13'(sw_en), 13'(i >= 2));
            chk(13'(ilim), 13'(lim[i]));
        end
        $display("levels test done");
    endtask : t_levels
    task t_boot;
        int n;
        int guard;
        @(posedge sys_clk);
        vout <= 11'h383;
        ready <= 1'b1;
        repeat (10) @(negedge sys_clk);
        chk(13'(ipg), 13'h0);
        chk(13'(target), 13'h3e8);
        @(posedge sys_clk);
        vout <= 11'h44c;
        n = 0;
        guard = 0;
        while (done !== 1'b1 && guard < 400) begin
            @(negedge sys_clk);
            guard++;
            n = (cpg === 1'b1) ? n + 1 : 0;
        end
        chk(13'(done), 13'h1);
        if (done !== 1'b1) begin
            hung = 1'b1;
            return;
        end
        chk(13'(n >= 115 && n <= 122), 13'h1);
        chk(13'(ipg), 13'h1);
        chk(13'(cpg), 13'h1);
        repeat (2) @(negedge sys_clk);
        chk(13'(target), 13'h2bc);
        @(posedge sys_clk);
        code_req <= 6'h00;
        repeat (6) @(negedge sys_clk);
        chk(13'(target), 13'h6ac);
        $display("boot test done");
    endtask : t_boot
    task t_restart;
        int n;
        int guard;
        @(posedge sys_clk);
        ss <= 13'h0190;
        repeat (8) @(negedge sys_clk);
        chk(13'(sd), 13'h1);
        chk(13'(sw_en), 13'h0);
        chk(13'(done), 13'h0);
        chk(13'(target), 13'h3e8);
        @(posedge sys_clk);
        ss <= 13'h0bb8;
        guard = 0;
        while (cpg !== 1'b1 && guard < 100) begin
            @(negedge sys_clk);
            guard++;
        end
        chk(13'(cpg), 13'h1);
        if (cpg !== 1'b1) begin
            hung = 1'b1;
            return;
        end
        repeat (40) @(negedge sys_clk);
        chk(13'(done), 13'h0);
        @(posedge sys_clk);
        ready <= 1'b0;
        repeat (8) @(negedge sys_clk);
        chk(13'(ipg), 13'h1);
        chk(13'(cpg), 13'h0);
        chk(13'(done), 13'h0);
        @(posedge sys_clk);
        ready <= 1'b1;
        n = 0;
        guard = 0;
        while (done !== 1'b1 && guard < 400) begin
            @(negedge sys_clk);
            guard++;
            n = (cpg === 1'b1) ? n + 1 : 0;
        end
        chk(13'(done), 13'h1);
        if (done !== 1'b1) begin
            hung = 1'b1;
            return;
        end
        chk(13'(n >= 115 && n <= 122), 13'h1);
        repeat (2) @(negedge sys_clk);
        chk(13'(target), 13'h6ac);
        $display("restart test done");
    endtask : t_restart
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_levels();
        t_boot();
        if (!hung) begin
            t_restart();
        end
        summarize();
    end
endmodule : test_regulator_startup_sequencer
`default_nettype wire
